//--- common/float_addsub_pkg.sv
// Constants, types and the instruction decoder of the floating add, subtract and magnitude unit.
package float_addsub_pkg;

  // ---------------------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PIB = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OPW0 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_OPW1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OPW2 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_GR = 8'h40;
  localparam logic [ADDR_W-1:0] GR_MASK = 8'hc3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ILLEGAL = 2;
  localparam int STAT_CS_LSB = 4;
  localparam int STAT_BASE_LSB = 8;
  localparam int PIB_OVF = 3;
  localparam int PIB_UNF = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Opcodes and clock counts.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_EXT_ADD = 8'haa;
  localparam logic [7:0] OP_EXT_ADD_REG = 8'hab;
  localparam logic [7:0] OP_MAG = 8'hac;
  localparam logic [7:0] OP_SUB = 8'hb8;
  localparam logic [7:0] OP_SUB_REG = 8'hb9;
  localparam logic [7:0] OP_EXT_SUB = 8'hba;
  localparam logic [7:0] OP_EXT_SUB_REG = 8'hbb;
  localparam logic [3:0] BASED_NIB = 4'h2;
  localparam logic [1:0] BASED_SUB_SEL = 2'h1;
  localparam logic [3:0] BASED_IDX_NIB = 4'h4;
  localparam logic [1:0] BASED_IDX_SEL = 2'h0;
  localparam logic [3:0] BASED_IDX_SUB = 4'h9;
  localparam logic [3:0] BASE_REG_LOW = 4'hc;
  localparam logic [7:0] CYC_EXT_MEM = 8'd78;
  localparam logic [7:0] CYC_EXT_REG = 8'd71;
  localparam logic [7:0] CYC_SUB_MEM = 8'd68;
  localparam logic [7:0] CYC_SUB_REG = 8'd62;
  localparam logic [7:0] CYC_BASED = 8'd67;
  localparam logic [7:0] CYC_MAG_POS = 8'd16;
  localparam logic [7:0] CYC_MAG_NEG = 8'd62;

  // ---------------------------------------------------------------------------
  // Number format and condition codes.
  // ---------------------------------------------------------------------------
  localparam logic signed [8:0] EXP_TOP = 9'sh07f;
  localparam logic signed [8:0] EXP_BOT = 9'sh180;
  localparam logic [39:0] MANT_POS_MAX = 40'h7fffffffff;
  localparam logic [39:0] MANT_NEG_MIN = 40'h8000000000;
  localparam logic [39:0] MANT_HALF = 40'h4000000000;
  localparam logic [39:0] MASK_SINGLE = 40'hffffff0000;
  localparam logic [39:0] MASK_EXT = 40'hffffffffff;
  localparam logic [3:0] CS_ZERO = 4'h2;
  localparam logic [3:0] CS_NEG = 4'h1;
  localparam logic [3:0] CS_POS = 4'h4;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_LOAD = 7'h02,
    ST_ALIGN = 7'h04,
    ST_ARITH = 7'h08,
    ST_NORM = 7'h10,
    ST_STORE = 7'h20,
    ST_HOLD = 7'h40
  } state_e;

  typedef struct packed {
    logic ok;
    logic ext;
    logic sub;
    logic mag;
    logic mem;
    logic based;
    logic [3:0] dest;
    logic [3:0] src;
    logic [3:0] base;
    logic [7:0] cyc;
  } dec_s;

  // Decodes one instruction word.
  function automatic dec_s decode(input logic [15:0] w);
    dec_s d;
    d = '0;
    d.ok = 1'b1;
    d.dest = w[7:4];
    d.src = w[3:0];
    case (w[15:8])
      OP_EXT_ADD:
      begin
        d.ext = 1'b1; d.mem = 1'b1; d.cyc = CYC_EXT_MEM;
      end
      OP_EXT_ADD_REG:
      begin
        d.ext = 1'b1; d.cyc = CYC_EXT_REG;
      end
      OP_MAG:
      begin
        d.mag = 1'b1; d.cyc = CYC_MAG_POS;
      end
      OP_SUB:
      begin
        d.sub = 1'b1; d.mem = 1'b1; d.cyc = CYC_SUB_MEM;
      end
      OP_SUB_REG:
      begin
        d.sub = 1'b1; d.cyc = CYC_SUB_REG;
      end
      OP_EXT_SUB:
      begin
        d.ext = 1'b1; d.sub = 1'b1; d.mem = 1'b1; d.cyc = CYC_EXT_MEM;
      end
      OP_EXT_SUB_REG:
      begin
        d.ext = 1'b1; d.sub = 1'b1; d.cyc = CYC_EXT_REG;
      end
      default:
      begin
        if ((w[15:12] == BASED_NIB && w[11:10] == BASED_SUB_SEL) ||
            (w[15:12] == BASED_IDX_NIB && w[11:10] == BASED_IDX_SEL && w[7:4] == BASED_IDX_SUB))
        begin
          d.sub = 1'b1; d.mem = 1'b1; d.based = 1'b1;
          d.dest = 4'h0;
          d.base = BASE_REG_LOW + {2'b00, w[9:8]};
          d.cyc = CYC_BASED;
        end
        else
        begin
          d.ok = 1'b0;
        end
      end
    endcase
    return d;
  endfunction

endpackage

//--- rtl/float_addsub_abs_unit.sv
// Floating add, subtract and magnitude unit behind an AXI4-Lite register slave.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
module float_addsub_abs_unit
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [float_addsub_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // Write data channel.
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel.
  input wire logic [float_addsub_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // Read data channel.
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import float_addsub_pkg::*;

  state_e state;
  dec_s op;
  logic [15:0] gr [16];
  logic [15:0] opw [3];
  logic [15:0] insn;
  logic [39:0] ma, mo, src_m, dst_m, mask;
  logic signed [8:0] ea, eo, src_e, dst_e;
  logic [40:0] sum41;
  logic [39:0] fixed;
  logic fraction_carry_out, norm_need, shift_cyc, busy;
  logic [7:0] timer;
  logic [3:0] cs;
  logic [15:0] pib;
  logic done, illegal;
  logic pi3_set, pi6_set;
  logic aw_have, w_have, wr_go, start;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdat, rd;
  logic [3:0] wstb;
  logic next_aw_have, next_w_have, next_bvalid, next_rvalid;
  logic [15:0] wval;
  dec_s wdec;

  // Builds a mantissa from the first word, the high byte of the second and, in extended format only, the third word.
  function automatic logic [39:0] mant(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c, input logic ext);
    return {a, b[15:8], ext ? c : 16'h0000};
  endfunction

  // Sign-extends the exponent byte.
  function automatic logic signed [8:0] expo(input logic [15:0] b);
    return {b[7], b[7:0]};
  endfunction

  // Arithmetic right shift by one place.
  function automatic logic [39:0] asr1(input logic [39:0] x);
    return {x[39], x[39:1]};
  endfunction

  // Tells whether a byte address holds a register.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a inside {OFF_CTRL, OFF_STAT, OFF_PIB, OFF_OPW0, OFF_OPW1, OFF_OPW2}) ||
           ((a & GR_MASK) == OFF_GR);
  endfunction

  // ---------------------------------------------------------------------------
  // Operands and arithmetic.
  // ---------------------------------------------------------------------------
  assign busy = (state != ST_IDLE);
  assign src_m = op.mem ? mant(opw[0], opw[1], opw[2], op.ext) :
                 mant(gr[op.src], gr[op.src + 4'd1], gr[op.src + 4'd2], op.ext);
  assign src_e = op.mem ? expo(opw[1]) : expo(gr[op.src + 4'd1]);
  assign dst_m = mant(gr[op.dest], gr[op.dest + 4'd1], gr[op.dest + 4'd2], op.ext);
  assign dst_e = expo(gr[op.dest + 4'd1]);
  assign mask = op.ext ? MASK_EXT : MASK_SINGLE;
  assign sum41 = op.sub ? ({ma[39], ma} - {mo[39], mo}) : ({ma[39], ma} + {mo[39], mo});
  assign fraction_carry_out = sum41[40] ^ sum41[39];
  assign fixed = {~sum41[39], sum41[39:1]};
  assign norm_need = (ma != 40'h0) && (ma[39] == ma[38]);
  assign shift_cyc = (state == ST_ALIGN && ma != 40'h0 && mo != 40'h0 && ea != eo) ||
                     (state == ST_NORM && norm_need && ea != EXP_BOT);
  assign pi3_set = (state == ST_ARITH && fraction_carry_out && ea == EXP_TOP) ||
                   (state == ST_LOAD && op.mag && src_m == MANT_NEG_MIN && src_e == EXP_TOP);
  assign pi6_set = (state == ST_NORM && norm_need && ea == EXP_BOT);

  // ---------------------------------------------------------------------------
  // Sequencer and datapath.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      ma <= 40'h0;
      mo <= 40'h0;
      ea <= 9'sh000;
      eo <= 9'sh000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (start)
            state <= ST_LOAD;
        end
        ST_LOAD:
        begin
          // All operands are read here before anything is written back.
          ma <= dst_m;
          ea <= dst_e;
          mo <= src_m;
          eo <= src_e;
          state <= ST_ALIGN;
          if (op.mag)
          begin
            ea <= src_e;
            state <= ST_STORE;
            if (!src_m[39])
              ma <= src_m;
            else if (src_m == MANT_NEG_MIN && src_e == EXP_TOP)
              ma <= MANT_POS_MAX & MASK_SINGLE;
            else if (src_m == MANT_NEG_MIN)
            begin
              ma <= MANT_HALF;
              ea <= src_e + 9'sd1;
            end
            else
              ma <= 40'h0 - src_m;
          end
        end
        ST_ALIGN:
        begin
          if (ma == 40'h0)
          begin
            ea <= eo;
            state <= ST_ARITH;
          end
          else if (mo != 40'h0 && ea > eo)
          begin
            mo <= asr1(mo) & mask;
            eo <= eo + 9'sd1;
          end
          else if (mo != 40'h0 && ea < eo)
          begin
            ma <= asr1(ma) & mask;
            ea <= ea + 9'sd1;
          end
          else
            state <= ST_ARITH;
        end
        ST_ARITH:
        begin
          state <= ST_NORM;
          if (fraction_carry_out && ea == EXP_TOP)
          begin
            ma <= fixed[39] ? MANT_NEG_MIN : (MANT_POS_MAX & mask);
            state <= ST_STORE;
          end
          else if (fraction_carry_out)
          begin
            ma <= fixed;
            ea <= ea + 9'sd1;
          end
          else
            ma <= sum41[39:0];
        end
        ST_NORM:
        begin
          if (ma == 40'h0 || (norm_need && ea == EXP_BOT))
          begin
            ma <= 40'h0;
            ea <= 9'sh000;
            state <= ST_STORE;
          end
          else if (!norm_need)
            state <= ST_STORE;
          else
          begin
            ma <= {ma[38:0], 1'b0};
            ea <= ea - 9'sd1;
          end
        end
        ST_STORE:
          state <= ST_HOLD;
        ST_HOLD:
        begin
          if (timer == 8'h00)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Counts out the listed time; shift cycles do not count, so each shift adds one.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer <= 8'h00;
    else if (state == ST_LOAD && op.mag)
      timer <= (src_m[39] ? CYC_MAG_NEG : CYC_MAG_POS) - 8'd2;
    else if (state == ST_LOAD)
      timer <= op.cyc - 8'd2;
    else if (busy && !shift_cyc && timer != 8'h00)
      timer <= timer - 8'd1;
  end

  // ---------------------------------------------------------------------------
  // Status, flags and instruction word.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cs <= 4'h0;
    else if (state == ST_STORE)
      cs <= (ma == 40'h0) ? CS_ZERO : (ma[39] ? CS_NEG : CS_POS);
  end

  // Pending bits are cleared by writing one; a new event wins over the clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pib <= 16'h0000;
    else
    begin
      pib <= (wr_go && waddr == OFF_PIB) ? (pib & ~wval) : pib;
      if (pi3_set)
        pib[PIB_OVF] <= 1'b1;
      if (pi6_set)
        pib[PIB_UNF] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      insn <= 16'h0000;
      op <= '0;
      done <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      if (wr_go && waddr == OFF_CTRL && !busy)
      begin
        insn <= wval;
        op <= wdec;
        illegal <= !wdec.ok;
      end
      if (start)
        done <= 1'b0;
      else if (state == ST_HOLD && timer == 8'h00)
        done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // General registers and operand words.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 16; i++)
        gr[i] <= 16'h0000;
      for (int i = 0; i < 3; i++)
        opw[i] <= 16'h0000;
    end
    else if (state == ST_STORE)
    begin
      gr[op.dest] <= ma[39:24];
      gr[op.dest + 4'd1] <= {ma[23:16], ea[7:0]};
      if (op.ext)
        gr[op.dest + 4'd2] <= ma[15:0];
    end
    else if (wr_go && !busy)
    begin
      if ((waddr & GR_MASK) == OFF_GR)
        gr[waddr[5:2]] <= wval;
      else if (waddr == OFF_OPW0)
        opw[0] <= wval;
      else if (waddr == OFF_OPW1)
        opw[1] <= wval;
      else if (waddr == OFF_OPW2)
        opw[2] <= wval;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave.
  // ---------------------------------------------------------------------------
  assign wr_go = aw_have && w_have && !bvalid;
  assign wdec = decode(wval);
  assign start = wr_go && waddr == OFF_CTRL && !busy && wdec.ok;
  assign next_aw_have = (aw_have || (awvalid && awready)) && !wr_go;
  assign next_w_have = (w_have || (wvalid && wready)) && !wr_go;
  assign next_bvalid = wr_go || (bvalid && !bready);
  assign next_rvalid = (arvalid && arready) || (rvalid && !rready);

  // Byte strobes act on the two low lanes of each 16-bit register.
  always_comb
  begin
    wval = 16'h0000;
    case (waddr)
      OFF_CTRL: wval = insn;
      OFF_OPW0: wval = opw[0];
      OFF_OPW1: wval = opw[1];
      OFF_OPW2: wval = opw[2];
      default: wval = ((waddr & GR_MASK) == OFF_GR) ? gr[waddr[5:2]] : 16'h0000;
    endcase
    if (waddr == OFF_PIB)
      wval = 16'h0000;
    if (wstb[0])
      wval[7:0] = wdat[7:0];
    if (wstb[1])
      wval[15:8] = wdat[15:8];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      waddr <= '0;
      wdat <= 32'h0;
      wstb <= 4'h0;
    end
    else
    begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      awready <= !next_aw_have && !next_bvalid;
      wready <= !next_w_have && !next_bvalid;
      bvalid <= next_bvalid;
      if (awvalid && awready)
        waddr <= awaddr;
      if (wvalid && wready)
      begin
        wdat <= wdata;
        wstb <= wstrb;
      end
      if (wr_go)
        bresp <= mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_comb
  begin
    rd = 32'h0;
    case (araddr)
      OFF_CTRL: rd[15:0] = insn;
      OFF_STAT:
      begin
        rd[STAT_BUSY] = busy;
        rd[STAT_DONE] = done;
        rd[STAT_ILLEGAL] = illegal;
        rd[STAT_CS_LSB +: 4] = cs;
        rd[STAT_BASE_LSB +: 4] = op.base;
      end
      OFF_PIB: rd[15:0] = pib;
      OFF_OPW0: rd[15:0] = opw[0];
      OFF_OPW1: rd[15:0] = opw[1];
      OFF_OPW2: rd[15:0] = opw[2];
      default: rd[15:0] = ((araddr & GR_MASK) == OFF_GR) ? gr[araddr[5:2]] : 16'h0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end
    else
    begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (arvalid && arready)
      begin
        rdata <= rd;
        rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [9:0] busy_cnt, shift_cnt, base_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == ST_IDLE)
    begin
      busy_cnt <= 10'd0;
      shift_cnt <= 10'd0;
      base_q <= 10'd0;
    end
    else
    begin
      busy_cnt <= busy_cnt + 10'd1;
      if (shift_cyc)
        shift_cnt <= shift_cnt + 10'd1;
      if (state == ST_LOAD)
        base_q <= {2'b00, op.mag ? (src_m[39] ? CYC_MAG_NEG : CYC_MAG_POS) : op.cyc};
    end
  end

  sequence s_arith_ovf;
    state == ST_ARITH && fraction_carry_out;
  endsequence
  sequence s_mag_neg;
    state == ST_LOAD && op.mag && src_m[39];
  endsequence

  property p_aligned;
    state == ST_ARITH && ma != 40'h0 && mo != 40'h0 |-> ea == eo;
  endproperty
  a_aligned: assert property (p_aligned) else $error("exponents unequal at add");
  property p_sub;
    state == ST_ARITH && op.sub && !fraction_carry_out |=> ma == $past(sum41[39:0]);
  endproperty
  a_sub: assert property (p_sub) else $error("difference not stored");
  property p_ovf_fix;
    s_arith_ovf ##0 (ea != EXP_TOP) |=> ea == $past(ea) + 9'sd1 && ma[39] == $past(sum41[40]);
  endproperty
  a_ovf_fix: assert property (p_ovf_fix) else $error("overflow correction wrong");
  property p_sat;
    s_arith_ovf ##0 (ea == EXP_TOP) |=> pib[PIB_OVF] && ea == EXP_TOP && state == ST_STORE
      && (ma == MANT_NEG_MIN || ma == (MANT_POS_MAX & mask));
  endproperty
  a_sat: assert property (p_sat) else $error("overflow not saturated");
  property p_unf;
    state == ST_NORM && norm_need && ea == EXP_BOT |=> pib[PIB_UNF] && ma == 40'h0 && ea == 9'sh000;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow not zeroed");
  property p_cs;
    state == ST_STORE |=> cs == ($past(ma) == 40'h0 ? CS_ZERO : ($past(ma[39]) ? CS_NEG : CS_POS));
  endproperty
  a_cs: assert property (p_cs) else $error("condition code wrong");
  property p_mag_pow2;
    s_mag_neg ##0 (src_m == MANT_NEG_MIN && src_e != EXP_TOP) |=> ma == MANT_HALF && ea == $past(src_e) + 9'sd1;
  endproperty
  a_mag_pow2: assert property (p_mag_pow2) else $error("power of two magnitude wrong");
  property p_mag_neg;
    s_mag_neg ##0 (src_m != MANT_NEG_MIN) |=> ma == 40'h0 - $past(src_m) ##2 gr[op.dest] == ma[39:24];
  endproperty
  a_mag_neg: assert property (p_mag_neg) else $error("negative magnitude wrong");
  property p_mag_pos;
    state == ST_LOAD && op.mag && !src_m[39] |=> ma == $past(src_m) && ea == $past(src_e);
  endproperty
  a_mag_pos: assert property (p_mag_pos) else $error("positive magnitude changed");
  property p_time;
    state == ST_HOLD && timer == 8'h00 |-> busy_cnt + 10'd1 == base_q + shift_cnt;
  endproperty
  a_time: assert property (p_time) else $error("execution time wrong");

endmodule

//--- verification/axil_host_model.sv
// Bus master model that stands in for the host side of the unit.
module axil_host_model
(
  // Clock.
  input wire logic aclk,
  // Write channels.
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels.
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {awaddr, awprot, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

//--- verification/float_addsub_abs_unit_tb.sv
// Self-checking bench of the floating add, subtract and magnitude unit.
module float_addsub_abs_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import float_addsub_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] v;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  float_addsub_abs_unit i_float_addsub_abs_unit (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  axil_host_model i_m (.aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  task automatic print_verdict;
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic gw(input logic [3:0] i, input logic [15:0] d);
    i_m.wr(OFF_GR + {2'b00, i, 2'b00}, d, rs);
  endtask
  task automatic gr(input logic [3:0] i, input logic [15:0] e);
    i_m.rd(OFF_GR + {2'b00, i, 2'b00}, v, rs);
    chk(v, {16'h0000, e});
  endtask
  // Starts one instruction, waits for done and checks the condition code.
  task automatic run(input logic [15:0] ins, input logic [3:0] cs);
    i_m.wr(OFF_CTRL, ins, rs);
    v = '0;
    for (int k = 0; k < 100 && v[STAT_DONE] !== 1'b1; k++)
      i_m.rd(OFF_STAT, v, rs);
    chk({31'h0, v[STAT_DONE]}, 32'h1);
    chk({28'h0, v[7:4]}, {28'h0, cs});
  endtask
  // Loads operands, runs one instruction and checks the stored pair and condition code.
  task automatic op(input logic [15:0] ins, input logic [63:0] ds, input logic [31:0] e, input logic [3:0] cs);
    gw(ins[7:4], ds[63:48]);
    gw(ins[7:4] + 4'h1, ds[47:32]);
    gw(ins[3:0], ds[31:16]);
    gw(ins[3:0] + 4'h1, ds[15:0]);
    run(ins, cs);
    gr(ins[7:4], e[31:16]);
    gr(ins[7:4] + 4'h1, e[15:0]);
  endtask
  task automatic pib(input logic [31:0] e);
    i_m.rd(OFF_PIB, v, rs);
    chk(v, e);
    i_m.wr(OFF_PIB, 16'h00ff, rs);
  endtask
  task automatic t_mag;
    op(16'hac44, 64'ha000_0001_a000_0001, 32'h6000_0001, CS_POS);
    op(16'hac86, 64'h0000_0000_8000_0002, 32'h4000_0003, CS_POS);
    op(16'hac86, 64'h0000_0000_5234_5602, 32'h5234_5602, CS_POS);
    pib(32'h0);
    op(16'hac86, 64'h0000_0000_8000_007f, 32'h7fff_ff7f, CS_POS);
    pib(32'h8);
  endtask
  task automatic t_sub;
    op(16'hb902, 64'h4000_0002_4000_0001, 32'h4000_0001, CS_POS);
    op(16'hb902, 64'h4000_0001_4000_0001, 32'h0, CS_ZERO);
    op(16'hb902, 64'h4000_0001_6000_0001, 32'h8000_00ff, CS_NEG);
    op(16'hb902, 64'h4000_007f_8000_007f, 32'h7fff_ff7f, CS_POS);
    pib(32'h8);
    op(16'hb902, 64'h4000_0081_7fff_ff80, 32'h0, CS_ZERO);
    pib(32'h40);
  endtask
  task automatic t_ext;
    gw(4'h2, 16'h0000);
    gw(4'h5, 16'h0000);
    op(16'hab03, 64'h4000_0001_4000_0001, 32'h4000_0002, CS_POS);
    gr(4'h2, 16'h0000);
    i_m.rd(8'h30, v, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    i_m.wr(8'h30, 16'h0000, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
  endtask
  // Memory, based and extended forms, the source coming from the operand words except in the extended register subtract.
  task automatic t_mem;
    gw(4'h1, 16'h4000);
    gw(4'h2, 16'h0002);
    i_m.wr(OFF_OPW0, 16'h4000, rs);
    i_m.wr(OFF_OPW1, 16'h0001, rs);
    run(16'hb810, CS_POS);
    gr(4'h1, 16'h4000);
    gr(4'h2, 16'h0001);
    gw(4'h0, 16'h4000);
    gw(4'h1, 16'h0001);
    run(16'h2500, CS_ZERO);
    chk({28'h0, v[STAT_BASE_LSB +: 4]}, 32'hd);
    gr(4'h0, 16'h0000);
    run(16'h4393, CS_NEG);
    chk({28'h0, v[STAT_BASE_LSB +: 4]}, 32'hf);
    gr(4'h0, 16'h8000);
    gr(4'h1, 16'h0000);
    gw(4'h0, 16'h4000);
    gw(4'h1, 16'h0002);
    gw(4'h2, 16'h0000);
    gw(4'h3, 16'h4000);
    gw(4'h4, 16'h0001);
    gw(4'h5, 16'h0002);
    run(16'hbb03, CS_POS);
    gr(4'h0, 16'h7fff);
    gr(4'h1, 16'hff00);
    gr(4'h2, 16'hfffc);
    i_m.wr(OFF_OPW0, 16'h8000, rs);
    i_m.wr(OFF_OPW1, 16'h0000, rs);
    i_m.wr(OFF_OPW2, 16'h0000, rs);
    run(16'haa00, CS_NEG);
    gr(4'h0, 16'h8000);
    gr(4'h1, 16'h00db);
    gr(4'h2, 16'h0000);
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_mag();
    t_sub();
    t_ext();
    t_mem();
    print_verdict();
  end
endmodule
